// ---- acs_pkg.sv ----
/*
   acs_pkg: shared constants and types for the converter slot sequencer.
   assumes: included before acs_slot_sequencer; no clock or reset inside.
*/
package acs_pkg;

   // register offsets on the internal register port
   localparam logic [7:0] OFS_EXT_A_RESULT   = 8'h24;
   localparam logic [7:0] OFS_EXT_B_RESULT   = 8'h25;
   localparam logic [7:0] OFS_TEMP_RESULT    = 8'h26;
   localparam logic [7:0] OFS_DIAG_RESULT    = 8'h27;
   localparam logic [7:0] OFS_OFFSET_VALUE   = 8'h28;
   localparam logic [7:0] OFS_CONV_CFG       = 8'h30;
   localparam logic [7:0] OFS_INDEX_CFG      = 8'h31;
   localparam logic [7:0] OFS_TRIGGER        = 8'h32;
   localparam logic [7:0] OFS_STATUS         = 8'h33;

   // slot assignment
   localparam logic [3:0] SLOT_OFFSET        = 4'h0;
   localparam logic [3:0] SLOT_EXT_A         = 4'h1;
   localparam logic [3:0] SLOT_EXT_B         = 4'h2;
   localparam logic [3:0] SLOT_TEMP          = 4'h3;
   localparam logic [3:0] SLOT_DIAG_FIRST    = 4'h4;
   localparam logic [3:0] SLOT_DIAG_OUTPUT   = 4'h8;

   // reset values
   localparam logic [3:0] START_RESET        = 4'h0;
   localparam logic [3:0] STOP_RESET         = 4'h8;
   localparam logic [5:0] CFG_RESET          = 6'h00;

   // field positions
   localparam int TRIG_BIT      = 0;
   localparam int BUSY_BIT      = 0;

   // offset calibration target (mid code minus one)
   localparam logic [11:0] OFFSET_TARGET     = 12'h7FF;
   localparam logic [11:0] CODE_MAX          = 12'hFFF;
   localparam logic [11:0] CODE_ZERO         = 12'h000;

   // timing: converter clock is the oscillator divided down
   localparam int OSC_HZ        = 1228800;
   localparam int ADC_DIV       = 16;
   localparam int ADC_HZ        = OSC_HZ / ADC_DIV;
   localparam int CORE_HZ       = 250000000;
   // least time per converter clock, rounded up
   localparam int ADC_TICK_CYC  = (CORE_HZ + ADC_HZ - 1) / ADC_HZ;
   localparam int CONV_MIN_CLKS = 20;
   localparam int RATE_SLOW_HZ  = 640;
   localparam int RATE_LOW_HZ   = 1280;
   localparam int RATE_MID_HZ   = 2560;
   localparam int RATE_FAST_HZ  = 3840;
   // converter clocks per conversion for each data rate
   localparam logic [7:0] LEN_SLOW = 8'(ADC_HZ / RATE_SLOW_HZ);
   localparam logic [7:0] LEN_LOW  = 8'(ADC_HZ / RATE_LOW_HZ);
   localparam logic [7:0] LEN_MID  = 8'(ADC_HZ / RATE_MID_HZ);
   localparam logic [7:0] LEN_FAST = 8'(ADC_HZ / RATE_FAST_HZ);

   // conversion configuration register
   typedef struct packed {
      logic       offset_correction_skip;
      logic       ext_b_analog_en;
      logic       external_range_select;
      logic [1:0] external_rate_select;
      logic       direct_mode;
   } acs_cfg_t;

   // start and stop index register
   typedef struct packed {
      logic [3:0] stop_index;
      logic [3:0] start_index;
   } acs_index_t;

   // register-side request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } acs_req_t;

   // sequencer state
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_CONV  = 3'b010,
      ST_STORE = 3'b100
   } acs_state_t;

endpackage

// ---- acs_slot_sequencer.sv ----
/*
   acs_slot_sequencer: sequencer, pacing, offset calibration and result
   registers of a 12-bit diagnostic converter.
   assumes: the analog core converts the slot on mux_sel_o while
   conv_active_o is high and holds its result on conv_result_i at the end;
   the supply comparator and result come from outside the clock domain.
*/
// Summary of operation
// - sixteen slots bounded by start, stop index
// - one-shot converts start through stop once
// - continuous wraps to start while enabled
// - fixed slot order, 9-15 read ground
// - equal indices convert just one slot
// - reset start 0, stop 8
// - unconfigured second input reads zero, time kept
// - start above stop acts as stop=start
// - continuous stops after current slot on 0
// - one-shot pass self-clears trigger bit
// - converter clock oscillator/16, twenty clocks minimum
// - internal slots fixed 2560 Hz, reference scale except slot 8
// - external slots use selected data rate
// - range bit picks double or single scale
// - low output supply blocks wide range
// - output monitor scale follows supply level
// - offset slot stores 7FFh minus result
// - offset subtracted unless skip bit set
// - straight binary twelve-bit results, saturating
// - results land in per-channel registers, slots 4-8 share one
// - busy high while sequence converts
`timescale 1ns/10ps
module acs_slot_sequencer #(
   parameter int TICK_CYC = acs_pkg::ADC_TICK_CYC
) (
   // clock, reset, enable
   input  wire logic              core_clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // register port
   input  wire acs_pkg::acs_req_t reg_req_i,
   output logic [15:0]            reg_rdata_o,
   // analog core
   input  wire logic [11:0]       conv_result_i,
   input  wire logic              supply_high_i,
   output logic [3:0]             mux_sel_o,
   output logic                   conv_active_o,
   output logic                   full_scale_double_o,
   // status
   output logic                   converter_busy_flag_o
);
   import acs_pkg::*;

   acs_state_t  state_ff;
   acs_cfg_t    cfg_ff;
   acs_index_t  index_ff;
   logic        trig_ff;
   logic [3:0]  slot_ff;
   logic [7:0]  adc_cnt_ff;
   logic [11:0] div_cnt_ff;
   logic [15:0] ext_a_ff;
   logic [15:0] ext_b_ff;
   logic [15:0] temp_ff;
   logic [15:0] diag_ff;
   logic [15:0] offset_ff;
   logic [15:0] rdata_ff;
   logic        sup_meta_ff;
   logic        sup_ff;
   logic [11:0] res_meta_ff;
   logic [11:0] res_ff;
   logic [3:0]  eff_stop;
   logic [7:0]  slot_len;
   logic        tick;
   logic        last_slot;
   logic        trig_set;
   logic        wr_cfg;
   logic        wr_index;
   logic [11:0] nxt_result;

   // converter clocks for one conversion of a slot
   function automatic logic [7:0] conv_len(input logic [3:0] slot, input logic [1:0] rate);
      logic [7:0] len;
      len = LEN_MID;
      if (slot == SLOT_EXT_A || slot == SLOT_EXT_B) begin
         unique case (rate)
            2'h0: len = LEN_SLOW;
            2'h1: len = LEN_LOW;
            2'h2: len = LEN_MID;
            2'h3: len = LEN_FAST;
         endcase
      end
      return len;
   endfunction

   // outside levels pass two flops
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sup_meta_ff <= 1'b0;
         sup_ff      <= 1'b0;
         res_meta_ff <= 12'h000;
         res_ff      <= 12'h000;
      end else if (ce_i) begin
         sup_meta_ff <= supply_high_i;
         sup_ff      <= sup_meta_ff;
         res_meta_ff <= conv_result_i;
         res_ff      <= res_meta_ff;
      end
   end

   // decode and derived terms
   assign wr_cfg    = reg_req_i.wr && reg_req_i.addr == OFS_CONV_CFG;
   assign wr_index  = reg_req_i.wr && reg_req_i.addr == OFS_INDEX_CFG;
   assign trig_set  = reg_req_i.wr && reg_req_i.addr == OFS_TRIGGER
                      && reg_req_i.wdata[TRIG_BIT];
   assign eff_stop  = (index_ff.start_index > index_ff.stop_index) ?
                      index_ff.start_index : index_ff.stop_index;
   assign last_slot = slot_ff == eff_stop;
   assign slot_len  = conv_len(slot_ff, cfg_ff.external_rate_select);
   assign tick      = div_cnt_ff == 12'(TICK_CYC - 1);

   // configuration registers, reset to full real-channel range
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_ff   <= acs_cfg_t'(CFG_RESET);
         index_ff <= '{stop_index: STOP_RESET, start_index: START_RESET};
      end else if (ce_i) begin
         if (wr_cfg) begin
            cfg_ff <= acs_cfg_t'(reg_req_i.wdata[5:0]);
            // range bit cannot be set while supply is low
            cfg_ff.external_range_select <= reg_req_i.wdata[3] && sup_ff;
         end
         if (wr_index) begin
            index_ff <= acs_index_t'(reg_req_i.wdata[7:0]);
         end
      end
   end

   // trigger bit: a write of one wins over the self-clear
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         trig_ff <= 1'b0;
      end else if (ce_i) begin
         if (trig_set) begin
            trig_ff <= 1'b1;
         end else if (reg_req_i.wr && reg_req_i.addr == OFS_TRIGGER) begin
            trig_ff <= 1'b0;
         end else if (state_ff == ST_STORE && last_slot && cfg_ff.direct_mode) begin
            trig_ff <= 1'b0;
         end
      end
   end

   // sequencer state and slot pointer
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         slot_ff  <= START_RESET;
      end else if (ce_i) begin
         unique case (state_ff)
            ST_IDLE: begin
               if (trig_ff) begin
                  state_ff <= ST_CONV;
                  slot_ff  <= index_ff.start_index;
               end
            end
            ST_CONV: begin
               if (tick && adc_cnt_ff == slot_len - 8'h01) begin
                  state_ff <= ST_STORE;
               end
            end
            ST_STORE: begin
               if (!trig_ff) begin
                  state_ff <= ST_IDLE;
               end else if (last_slot && cfg_ff.direct_mode) begin
                  state_ff <= ST_IDLE;
               end else if (last_slot) begin
                  state_ff <= ST_CONV;
                  slot_ff  <= index_ff.start_index;
               end else begin
                  state_ff <= ST_CONV;
                  slot_ff  <= slot_ff + 4'h1;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // converter clock divider restarts with each slot
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_cnt_ff <= 12'h000;
         adc_cnt_ff <= 8'h00;
      end else if (ce_i) begin
         if (state_ff != ST_CONV) begin
            div_cnt_ff <= 12'h000;
            adc_cnt_ff <= 8'h00;
         end else if (tick) begin
            div_cnt_ff <= 12'h000;
            adc_cnt_ff <= adc_cnt_ff + 8'h01;
         end else begin
            div_cnt_ff <= div_cnt_ff + 12'h001;
         end
      end
   end

   // offset correction and saturation to straight binary
   always_comb begin
      logic signed [13:0] diff;
      diff = $signed({2'b00, res_ff}) - $signed(offset_ff[13:0]);
      if (cfg_ff.offset_correction_skip) begin
         diff = $signed({2'b00, res_ff});
      end
      if (diff < 0) begin
         nxt_result = CODE_ZERO;
      end else if (diff > $signed({2'b00, CODE_MAX})) begin
         nxt_result = CODE_MAX;
      end else begin
         nxt_result = diff[11:0];
      end
      if (slot_ff == SLOT_EXT_B && !cfg_ff.ext_b_analog_en) begin
         nxt_result = CODE_ZERO;
      end
   end

   // result and offset registers
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ext_a_ff  <= 16'h0000;
         ext_b_ff  <= 16'h0000;
         temp_ff   <= 16'h0000;
         diag_ff   <= 16'h0000;
         offset_ff <= 16'h0000;
      end else if (ce_i && state_ff == ST_STORE) begin
         if (slot_ff == SLOT_OFFSET) begin
            offset_ff <= 16'($signed({1'b0, OFFSET_TARGET}) - $signed({1'b0, res_ff}));
         end else if (slot_ff == SLOT_EXT_A) begin
            ext_a_ff <= {4'h0, nxt_result};
         end else if (slot_ff == SLOT_EXT_B) begin
            ext_b_ff <= {4'h0, nxt_result};
         end else if (slot_ff == SLOT_TEMP) begin
            temp_ff <= {4'h0, nxt_result};
         end else if (slot_ff <= SLOT_DIAG_OUTPUT) begin
            diag_ff <= {4'h0, nxt_result};
         end
      end
   end

   // register read data, one cycle after the read strobe
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_ff <= 16'h0000;
      end else if (ce_i && reg_req_i.rd) begin
         unique case (reg_req_i.addr)
            OFS_EXT_A_RESULT: rdata_ff <= ext_a_ff;
            OFS_EXT_B_RESULT: rdata_ff <= ext_b_ff;
            OFS_TEMP_RESULT:  rdata_ff <= temp_ff;
            OFS_DIAG_RESULT:  rdata_ff <= diag_ff;
            OFS_OFFSET_VALUE: rdata_ff <= offset_ff;
            OFS_CONV_CFG:     rdata_ff <= {10'h000, cfg_ff};
            OFS_INDEX_CFG:    rdata_ff <= {8'h00, index_ff};
            OFS_TRIGGER:      rdata_ff <= {15'h0000, trig_ff};
            OFS_STATUS:       rdata_ff <= {15'h0000, state_ff != ST_IDLE};
            default:          rdata_ff <= 16'h0000;
         endcase
      end
   end

   // outputs toward analog core and host
   assign reg_rdata_o           = rdata_ff;
   assign mux_sel_o             = slot_ff;
   assign conv_active_o         = state_ff == ST_CONV;
   assign converter_busy_flag_o = state_ff != ST_IDLE;
   // external slots: range bit; output monitor: supply level
   assign full_scale_double_o   =
      ((slot_ff == SLOT_EXT_A || slot_ff == SLOT_EXT_B)
       && !cfg_ff.external_range_select && sup_ff)
      || (slot_ff == SLOT_DIAG_OUTPUT && sup_ff);

   // helper: core cycles spent in the current conversion, saturating
   logic [15:0] conv_cyc_ff;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         conv_cyc_ff <= 16'h0000;
      end else if (ce_i) begin
         if (state_ff != ST_CONV) begin
            conv_cyc_ff <= 16'h0000;
         end else if (conv_cyc_ff != 16'hFFFF) begin
            conv_cyc_ff <= conv_cyc_ff + 16'h0001;   // slow rates exceed 16 bits
         end
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   sequence store_last_s;
      ce_i && state_ff == ST_STORE && last_slot && trig_ff;
   endsequence

   busy_start_a: assert property (ce_i && state_ff == ST_IDLE && trig_ff
      |=> converter_busy_flag_o && conv_active_o && mux_sel_o == $past(index_ff.start_index))
      else $error("trigger did not start busy conversion at start slot");

   slot_bounds_a: assert property (state_ff == ST_CONV |->
      (slot_ff >= index_ff.start_index && slot_ff <= eff_stop) || $changed(index_ff))
      else $error("slot outside selected range");

   oneshot_end_a: assert property (store_last_s ##0 cfg_ff.direct_mode && !trig_set
      |=> state_ff == ST_IDLE && !trig_ff)
      else $error("one-shot pass did not halt and clear trigger");

   auto_wrap_a: assert property (store_last_s ##0 !cfg_ff.direct_mode
      |=> state_ff == ST_CONV && slot_ff == $past(index_ff.start_index))
      else $error("continuous mode did not wrap to start");

   stop_after_a: assert property (ce_i && state_ff == ST_STORE && !trig_ff
      |=> state_ff == ST_IDLE)
      else $error("conversion continued after trigger cleared");

   conv_time_a: assert property (ce_i && state_ff == ST_CONV ##1 state_ff == ST_STORE
      |-> conv_cyc_ff >= 16'(CONV_MIN_CLKS * TICK_CYC))
      else $error("conversion shorter than minimum");

   ext_b_zero_a: assert property (ce_i && state_ff == ST_STORE
      && slot_ff == SLOT_EXT_B && !cfg_ff.ext_b_analog_en |=> ext_b_ff == 16'h0000)
      else $error("unconfigured second input not zero");

   offset_calc_a: assert property (ce_i && state_ff == ST_STORE && slot_ff == SLOT_OFFSET
      |=> offset_ff == 16'($signed({1'b0, OFFSET_TARGET}) - $signed({1'b0, $past(res_ff)})))
      else $error("offset value wrong");

   range_block_a: assert property (!sup_ff |-> !full_scale_double_o)
      else $error("wide scale selected on low supply");

   range_lock_a: assert property (ce_i && wr_cfg && !sup_ff
      |=> !cfg_ff.external_range_select)
      else $error("range bit set while supply low");

   ext_a_store_a: assert property (ce_i && state_ff == ST_STORE && slot_ff == SLOT_EXT_A
      |=> ext_a_ff == {4'h0, $past(nxt_result)})
      else $error("first input result not stored");

   internal_rate_a: assert property (slot_ff != SLOT_EXT_A && slot_ff != SLOT_EXT_B
      |-> slot_len == LEN_MID)
      else $error("internal slot not at fixed rate");

endmodule

// ---- acs_slot_sequencer_test.sv ----
/*
   acs_slot_sequencer_test: self-checking bench for the slot sequencer.
   assumes: acs_pkg compiled first; the bench stands in for the host and
   the analog core, and drives every input on the falling clock edge.
*/
`timescale 1ns/10ps
module acs_slot_sequencer_test;
   import acs_pkg::*;

   localparam int T = 4;

   logic             core_clk_i;
   logic             rst_i;
   logic             ce_i;
   logic             supply_high_i;
   acs_req_t         reg_req_i;
   logic [11:0]      conv_result_i;
   logic [15:0]      reg_rdata_o;
   logic [3:0]       mux_sel_o;
   logic             conv_active_o;
   logic             full_scale_double_o;
   logic             converter_busy_flag_o;
   int               fail_count;
   int               compares;
   int               seed;
   int               i;
   logic [11:0]      raw [16];
   logic [15:0]      m_reg [5];
   logic             touched [5];
   logic [15:0]      d;

   acs_slot_sequencer #(.TICK_CYC(T)) dut (
      .core_clk_i            (core_clk_i),
      .rst_i                 (rst_i),
      .ce_i                  (ce_i),
      .reg_req_i             (reg_req_i),
      .reg_rdata_o           (reg_rdata_o),
      .conv_result_i         (conv_result_i),
      .supply_high_i         (supply_high_i),
      .mux_sel_o             (mux_sel_o),
      .conv_active_o         (conv_active_o),
      .full_scale_double_o   (full_scale_double_o),
      .converter_busy_flag_o (converter_busy_flag_o)
   );

   // core clock, 4 ns period
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end

   // analog core stand-in: raw code follows the selected slot
   always @(negedge core_clk_i) begin
      conv_result_i <= raw[mux_sel_o];
   end

   task conclude;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task wr(input logic [7:0] a, input logic [15:0] v);
      @(negedge core_clk_i);
      reg_req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(negedge core_clk_i);
      reg_req_i.wr = 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [15:0] v);
      @(negedge core_clk_i);
      reg_req_i.rd   = 1'b1;
      reg_req_i.addr = a;
      @(negedge core_clk_i);
      reg_req_i.rd = 1'b0;
      v = reg_rdata_o;
   endtask

   // cycles in conversion for a slot and rate code
   function automatic int exp_len(input logic [3:0] s, input logic [1:0] c);
      if (s != SLOT_EXT_A && s != SLOT_EXT_B) return 30 * T;
      case (c)
         2'd0: return 120 * T;
         2'd1: return 60 * T;
         2'd2: return 30 * T;
         default: return 20 * T;
      endcase
   endfunction

   // twice-reference scale expected for a slot
   function automatic logic exp_fsd(input logic [3:0] s, input logic r, input logic sup);
      if (s == SLOT_EXT_A || s == SLOT_EXT_B) return !r && sup;
      return (s == SLOT_DIAG_OUTPUT) && sup;
   endfunction

   // offset-corrected, saturated result
   function automatic logic [15:0] corr(input logic [11:0] r, input logic [15:0] off,
                                        input logic skip);
      int v;
      if (skip) return {4'h0, r};
      v = int'(r) - int'($signed(off));
      if (v < 0) v = 0;
      if (v > 4095) v = 4095;
      return 16'(v);
   endfunction

   // result register index of a slot, -1 for ground
   function automatic int ridx(input logic [3:0] s);
      if (s == SLOT_OFFSET) return 4;
      if (s <= SLOT_TEMP) return int'(s) - 1;
      if (s <= SLOT_DIAG_OUTPUT) return 3;
      return -1;
   endfunction

   // one sequence run with per-slot and final checks
   task run(input string name, input logic [3:0] st, input logic [3:0] sp,
            input logic [5:0] cfg, input int stop_after, input logic sup);
      int k, cnt, n, total, guard, x;
      logic [3:0] eff, es;
      logic [11:0] t;
      logic was, stopped;
      supply_high_i = sup;
      repeat (4) @(negedge core_clk_i);
      for (k = 0; k < 16; k++) raw[k] = 12'($random(seed));
      wr(OFS_CONV_CFG, {10'h000, cfg});
      wr(OFS_INDEX_CFG, {8'h00, sp, st});
      eff = (st > sp) ? st : sp;
      n = int'(eff) - int'(st) + 1;
      total = cfg[0] ? n : stop_after + 1;
      k = 0; cnt = 0; was = 1'b0; stopped = 1'b0; es = st;
      wr(OFS_TRIGGER, 16'h0001);
      for (guard = 0; guard < 20000; guard++) begin
         @(negedge core_clk_i);
         if (reg_req_i.wr) reg_req_i.wr = 1'b0;
         if (conv_active_o === 1'b1) begin
            if (cnt == 0) begin
               es = st + 4'(k % n);
               chk("slot", {12'h000, es}, {12'h000, mux_sel_o});
               chk("scale", {15'h0, exp_fsd(es, cfg[3] & sup, sup)},
                   {15'h0, full_scale_double_o});
               chk("busy", 16'h0001, {15'h0, converter_busy_flag_o});
            end
            cnt++;
            if (!cfg[0] && k == stop_after && cnt == 5 && !stopped) begin
               reg_req_i = '{wr: 1'b1, rd: 1'b0, addr: OFS_TRIGGER, wdata: 16'h0000};
               stopped = 1'b1;
            end
         end else if (was) begin
            chk("len", 16'(exp_len(es, cfg[2:1])), 16'(cnt));
            x = ridx(es);
            if (x == 4) begin
               t = OFFSET_TARGET - raw[SLOT_OFFSET];
               m_reg[4] = {{4{t[11]}}, t};
            end else if (x >= 0) begin
               m_reg[x] = (es == SLOT_EXT_B && !cfg[4]) ? 16'h0000
                        : corr(raw[es], m_reg[4], cfg[5]);
            end
            if (x >= 0) touched[x] = 1'b1;
            k++;
            cnt = 0;
         end
         was = (conv_active_o === 1'b1);
         if (k == total && converter_busy_flag_o === 1'b0) break;
      end
      chk("slots", 16'(total), 16'(k));
      if (k != total) conclude();
      chk("busy_end", 16'h0000, {15'h0, converter_busy_flag_o});
      rd(OFS_TRIGGER, d);
      chk("trigger", 16'h0000, d & 16'h0001);
      rd(OFS_STATUS, d);
      chk("status", 16'h0000, d);
      rd(OFS_CONV_CFG, d);
      chk("cfg", {10'h000, sup ? cfg : (cfg & 6'h37)}, d);
      for (x = 0; x < 5; x++) begin
         if (touched[x]) begin
            rd(OFS_EXT_A_RESULT + 8'(x), d);
            chk("result", m_reg[x], d);
         end
      end
      $display("test %s done", name);
   endtask

   // main sequence
   initial begin
      fail_count = 0;
      compares = 0;
      seed = 90371;
      rst_i = 1'b1;
      ce_i = 1'b1;
      supply_high_i = 1'b1;
      reg_req_i = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 16'h0000};
      for (i = 0; i < 16; i++) raw[i] = 12'h000;
      for (i = 0; i < 5; i++) begin
         m_reg[i] = 16'h0000;
         touched[i] = 1'b0;
      end
      repeat (10) @(negedge core_clk_i);
      rst_i = 1'b0;
      @(negedge core_clk_i);
      chk("busy_rst", 16'h0000, {15'h0, converter_busy_flag_o});
      rd(OFS_INDEX_CFG, d);
      chk("index_rst", 16'h0080, d);
      // a write with the enable low must leave the register alone
      ce_i = 1'b0;
      wr(OFS_INDEX_CFG, 16'h0012);
      ce_i = 1'b1;
      rd(OFS_INDEX_CFG, d);
      chk("ce_hold", 16'h0080, d);
      rd(OFS_CONV_CFG, d);
      chk("cfg_rst", 16'h0000, d);
      rd(8'h40, d);
      chk("unmapped", 16'h0000, d);
      run("full", 4'h0, 4'h8, 6'h07, 0, 1'b1);
      for (i = 0; i < 3; i++) begin
         run("rate", 4'h1, 4'h2, {i == 2, 1'b1, 1'b0, 2'(i), 1'b1}, 0, 1'b1);
      end
      run("swap", 4'h5, 4'h2, 6'h01, 0, 1'b1);
      run("auto", 4'h3, 4'h4, 6'h00, 3, 1'b1);
      run("low_supply", 4'h1, 4'h1, 6'h09, 0, 1'b0);
      run("range_one", 4'h1, 4'h1, 6'h09, 0, 1'b1);
      run("monitor_low", 4'h8, 4'h8, 6'h01, 0, 1'b0);
      // status reads busy during a one-shot ground slot, then idle
      wr(OFS_INDEX_CFG, 16'h0099);
      wr(OFS_TRIGGER, 16'h0001);
      rd(OFS_STATUS, d);
      chk("status_busy", 16'h0001, d);
      for (i = 0; i < 200 && converter_busy_flag_o !== 1'b0; i++) @(negedge core_clk_i);
      chk("status_idle", 16'h0000, {15'h0, converter_busy_flag_o});
      if (converter_busy_flag_o !== 1'b0) conclude();
      rd(OFS_TRIGGER, d);
      chk("trig_clear", 16'h0000, d & 16'h0001);
      wr(OFS_TEMP_RESULT, 16'h0ABC);
      rd(OFS_TEMP_RESULT, d);
      chk("ro_result", m_reg[2], d);
      for (i = 0; i < 4; i++) begin
         run("random", 4'($random(seed)), 4'($random(seed)),
             {2'($random(seed)), 1'b0, 2'($random(seed)), 1'b1}, 0, 1'b1);
      end
      conclude();
   end

endmodule
